/* File: design/shutdown_timebase_pkg.sv */
// Package with register map, field positions and reset values for the shutdown source and time base block.
package shutdown_timebase_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    // Register offsets; none are given by the device, so these are local choices.
    localparam logic [3:0] OFF_SRC_SEL    = 4'h0;
    localparam logic [3:0] OFF_TB_LOW     = 4'h1;
    localparam logic [3:0] OFF_TB_HIGH    = 4'h2;
    localparam logic [3:0] OFF_LEVEL      = 4'h3;
    localparam logic [3:0] OFF_TB_CTRL    = 4'h4;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h5;
    localparam logic [3:0] OFF_IRQ_ENABLE = 4'h6;
    localparam logic [3:0] OFF_IRQ_CLEAR  = 4'h7;

    // Shutdown source register fields.
    localparam int unsigned SRC_PIN_BIT  = 7;
    localparam int unsigned SRC_CMP3_BIT = 3;
    localparam int unsigned SRC_CMP2_BIT = 2;
    localparam int unsigned SRC_CMP1_BIT = 1;
    localparam logic [7:0]  SRC_IMPL_MASK = 8'h8e;

    // Reset values.
    localparam logic [7:0] SRC_RESET     = 8'h00;
    localparam logic [7:0] TB_LOW_RESET  = 8'h00;
    localparam logic [7:0] TB_HIGH_RESET = 8'h01;
    localparam logic [7:0] LEVEL_RESET   = 8'h00;

    // Interrupt status bits.
    localparam int unsigned IRQ_SHUTDOWN_BIT = 0;
    localparam int unsigned IRQ_WRAP_BIT     = 1;
    localparam int unsigned IRQ_W            = 2;

    localparam int unsigned TB_RUN_BIT = 0;
    localparam int unsigned NUM_OUTPUTS = 6;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic cmp3;
        logic cmp2;
        logic cmp1;
        logic pin;
    } shutdown_inputs_t;

endpackage : shutdown_timebase_pkg

/* File: design/shutdown_timebase.sv */
// Auto-shutdown source selection, forced output levels and software-visible 16-bit time base counter.
//
// Function
// - Pin source bit enables external pin shutdown.
// - Source bits 6-4 and 0 read zero.
// - Counter visible as readable, writable low/high bytes.
// - Reset: high byte 0x01, others cleared.
// - Shutdown drives outputs to their level bits.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps

module shutdown_timebase
    import shutdown_timebase_pkg::*;
#(
    parameter int unsigned N_OUT = NUM_OUTPUTS
) (
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire logic [ADDR_W-1:0]     reg_addr,
    input  wire logic [DATA_W-1:0]     reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [DATA_W-1:0]     reg_rdata,
    input  wire logic                  external_shutdown_input,
    input  wire logic                  synced_comparator1_out,
    input  wire logic                  synced_comparator2_out,
    input  wire logic                  synced_comparator3_out,
    input  wire logic [N_OUT-1:0]      pwm_in,
    output logic      [N_OUT-1:0]      pwm_out,
    output logic                       auto_shutdown,
    output logic                       irq
);

    if (N_OUT < 1 || N_OUT > DATA_W) begin : g_bad_n_out
        $error("N_OUT must lie between 1 and the data width");
    end

    reg_req_t         req;
    shutdown_inputs_t src;

    assign req = '{
        wr:    reg_wr,
        rd:    reg_rd,
        addr:  reg_addr,
        wdata: reg_wdata
    };

    // The pin arrives from outside, so it passes two flip-flops. The comparator outputs are already synchronised.
    logic pin_meta_q;
    logic pin_sync_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_q <= 1'b0;
            pin_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= external_shutdown_input;
            pin_sync_q <= pin_meta_q;
        end
    end

    assign src = '{
        cmp3: synced_comparator3_out,
        cmp2: synced_comparator2_out,
        cmp1: synced_comparator1_out,
        pin:  pin_sync_q
    };

    // Counter layout: the low byte holds the bottom half of the count, the high byte the top half.
    localparam int unsigned     TB_W     = 2 * DATA_W;
    localparam int unsigned     LOW_LSB  = 0;
    localparam int unsigned     HIGH_LSB = DATA_W;
    localparam logic [TB_W-1:0] TB_STEP  = TB_W'(1);

    // Register state.
    logic [DATA_W-1:0] src_sel_q;
    logic [DATA_W-1:0] level_q;
    logic              tb_run_q;
    logic [TB_W-1:0]   time_base_counter_q;
    logic [TB_W-1:0]   time_base_counter_d;
    logic [IRQ_W-1:0]  irq_status_q;
    logic [IRQ_W-1:0]  irq_status_d;
    logic [IRQ_W-1:0]  irq_enable_q;
    logic [DATA_W-1:0] rdata_q;

    // One decode function serves every write strobe, so no two registers can answer one offset.
    function automatic logic offset_hit(input logic              strobe,
                                        input logic [ADDR_W-1:0] addr,
                                        input logic [ADDR_W-1:0] off);
        return strobe && (addr == off);
    endfunction : offset_hit

    // Address decode.
    wire wr_src   = offset_hit(req.wr, req.addr, OFF_SRC_SEL);
    wire wr_low   = offset_hit(req.wr, req.addr, OFF_TB_LOW);
    wire wr_high  = offset_hit(req.wr, req.addr, OFF_TB_HIGH);
    wire wr_level = offset_hit(req.wr, req.addr, OFF_LEVEL);
    wire wr_ctrl  = offset_hit(req.wr, req.addr, OFF_TB_CTRL);
    wire wr_ien   = offset_hit(req.wr, req.addr, OFF_IRQ_ENABLE);
    wire wr_iclr  = offset_hit(req.wr, req.addr, OFF_IRQ_CLEAR);

    wire pin_shutdown_source_en  = src_sel_q[SRC_PIN_BIT];
    wire cmp1_shutdown_source_en = src_sel_q[SRC_CMP1_BIT];
    wire cmp2_shutdown_source_en = src_sel_q[SRC_CMP2_BIT];
    wire cmp3_shutdown_source_en = src_sel_q[SRC_CMP3_BIT];

    wire pin_hit  = pin_shutdown_source_en && src.pin;
    wire cmp1_hit = cmp1_shutdown_source_en && src.cmp1;
    wire cmp2_hit = cmp2_shutdown_source_en && src.cmp2;
    wire cmp3_hit = cmp3_shutdown_source_en && src.cmp3;

    // Shutdown follows the enabled sources as a level; a restart policy lives outside this block.
    wire shutdown_now = pin_hit || cmp1_hit || cmp2_hit || cmp3_hit;

    logic shutdown_q;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            shutdown_q <= 1'b0;
        end else begin
            shutdown_q <= shutdown_now;
        end
    end

    assign auto_shutdown = shutdown_q;

    // Forced levels replace the PWM drive while shut down.
    // Each output takes its own level bit, so one output may park high while another parks low.
    logic [N_OUT-1:0] pwm_out_q;
    logic [N_OUT-1:0] pwm_out_d;

    for (genvar i = 0; i < N_OUT; i++) begin : g_force
        assign pwm_out_d[i] = shutdown_now ? level_q[i] : pwm_in[i];
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pwm_out_q <= '0;
        end else begin
            pwm_out_q <= pwm_out_d;
        end
    end

    assign pwm_out = pwm_out_q;

    // Time base counter: byte writes take priority over counting so software sees exactly what it wrote.
    wire tb_wrap = tb_run_q && (&time_base_counter_q);

    always_comb begin
        time_base_counter_d = time_base_counter_q;
        if (tb_run_q) begin
            time_base_counter_d = time_base_counter_q + TB_STEP;
        end
        if (wr_low) begin
            time_base_counter_d[LOW_LSB +: DATA_W] = req.wdata;
        end
        if (wr_high) begin
            time_base_counter_d[HIGH_LSB +: DATA_W] = req.wdata;
        end
    end

    // Events set status bits; a set in the same cycle as a clear wins.
    wire shutdown_rise = shutdown_now && !shutdown_q;
    wire [IRQ_W-1:0] irq_events = {tb_wrap, shutdown_rise};

    always_comb begin
        irq_status_d = irq_status_q;
        if (wr_iclr) begin
            irq_status_d = irq_status_q & ~req.wdata[IRQ_W-1:0];
        end
        irq_status_d = irq_status_d | irq_events;
    end

    // Unimplemented source bits never store a one, so a read cannot expose stale writes.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            src_sel_q <= SRC_RESET;
        end else if (wr_src) begin
            src_sel_q <= req.wdata & SRC_IMPL_MASK;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            level_q <= LEVEL_RESET;
        end else if (wr_level) begin
            level_q <= req.wdata;
        end
    end

    // The counter stays halted after reset, so the reset value remains visible until software starts it.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            tb_run_q <= 1'b0;
        end else if (wr_ctrl) begin
            tb_run_q <= req.wdata[TB_RUN_BIT];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_enable_q <= '0;
        end else if (wr_ien) begin
            irq_enable_q <= req.wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            time_base_counter_q <= {TB_HIGH_RESET, TB_LOW_RESET};
        end else begin
            time_base_counter_q <= time_base_counter_d;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_status_q <= '0;
        end else begin
            irq_status_q <= irq_status_d;
        end
    end

    // Read values per register; unmapped offsets and the write-only clear register read as zero.
    wire [DATA_W-1:0] rd_src_val    = src_sel_q & SRC_IMPL_MASK;
    wire [DATA_W-1:0] rd_low_val    = time_base_counter_q[LOW_LSB +: DATA_W];
    wire [DATA_W-1:0] rd_high_val   = time_base_counter_q[HIGH_LSB +: DATA_W];
    wire [DATA_W-1:0] rd_ctrl_val   = {{(DATA_W-1){1'b0}}, tb_run_q};
    wire [DATA_W-1:0] rd_status_val = {{(DATA_W-IRQ_W){1'b0}}, irq_status_q};
    wire [DATA_W-1:0] rd_enable_val = {{(DATA_W-IRQ_W){1'b0}}, irq_enable_q};

    logic [DATA_W-1:0] rd_mux;

    always_comb begin
        unique case (req.addr)
            OFF_SRC_SEL:    rd_mux = rd_src_val;
            OFF_TB_LOW:     rd_mux = rd_low_val;
            OFF_TB_HIGH:    rd_mux = rd_high_val;
            OFF_LEVEL:      rd_mux = level_q;
            OFF_TB_CTRL:    rd_mux = rd_ctrl_val;
            OFF_IRQ_STATUS: rd_mux = rd_status_val;
            OFF_IRQ_ENABLE: rd_mux = rd_enable_val;
            default:        rd_mux = '0;
        endcase
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= req.rd ? rd_mux : '0;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq       = |(irq_status_q & irq_enable_q);

endmodule : shutdown_timebase

/* File: bench/shutdown_timebase_chk.sv */
// Port checker for the shutdown source and time base block.
`timescale 1ns/1ps
module shutdown_timebase_chk
    import shutdown_timebase_pkg::*;
#(
    parameter int unsigned N_OUT = NUM_OUTPUTS
) (
    input logic              mclk,
    input logic              resetn,
    input logic [ADDR_W-1:0] reg_addr,
    input logic [DATA_W-1:0] reg_wdata,
    input logic              reg_wr,
    input logic              reg_rd,
    input logic [DATA_W-1:0] reg_rdata,
    input logic              external_shutdown_input,
    input logic              synced_comparator1_out,
    input logic              synced_comparator2_out,
    input logic              synced_comparator3_out,
    input logic [N_OUT-1:0]  pwm_in,
    input logic [N_OUT-1:0]  pwm_out,
    input logic              auto_shutdown,
    input logic              irq
);
    logic [7:0]       src_q;
    logic [7:0]       ien_q;
    logic [N_OUT-1:0] lvl_q;
    logic [1:0]       pin_q;
    // Shadow copies of the written registers let the checker predict shutdown without seeing the body.
    wire exp_w = |({pin_q[1], synced_comparator3_out, synced_comparator2_out, synced_comparator1_out}
                   & {src_q[7], src_q[3:1]});
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            {src_q, ien_q, lvl_q, pin_q} <= '0;
        end else begin
            pin_q <= {pin_q[0], external_shutdown_input};
            if (reg_wr && reg_addr == OFF_SRC_SEL) src_q <= reg_wdata;
            if (reg_wr && reg_addr == OFF_IRQ_ENABLE) ien_q <= reg_wdata;
            if (reg_wr && reg_addr == OFF_LEVEL) lvl_q <= reg_wdata[N_OUT-1:0];
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
    src_rsvd_a: assert property ($past(reg_rd) && $past(reg_addr) == OFF_SRC_SEL |->
        (reg_rdata & 8'h71) == 8'h00) else $error("reserved source bits read nonzero");
    shut_exact_a: assert property ($past(resetn) |-> auto_shutdown == $past(exp_w))
        else $error("shutdown does not follow enabled sources");
    cmp_fires_a: assert property (synced_comparator1_out && src_q[1] |=> auto_shutdown)
        else $error("comparator shutdown missed");
    pin_fires_a: assert property ($rose(pin_q[1]) && src_q[7] |=> auto_shutdown) else $error("pin shutdown missed");
    out_level_a: assert property ($past(resetn) |->
        pwm_out == (auto_shutdown ? $past(lvl_q) : $past(pwm_in))) else $error("output level wrong");
    irq_off_a: assert property (ien_q == 8'h00 |-> !irq) else $error("irq while masked");
    irq_set_a: assert property ($rose(auto_shutdown) && ien_q[0] |-> ##[0:1] irq) else $error("irq missed");
endmodule : shutdown_timebase_chk

/* File: bench/shutdown_sources.sv */
// Model of the external shutdown pin and the three comparators.
`timescale 1ns/1ps
module shutdown_sources
    import shutdown_timebase_pkg::*;
(
    input  logic             mclk,
    input  shutdown_inputs_t cmd,
    output logic             external_shutdown_input,
    output logic             synced_comparator1_out,
    output logic             synced_comparator2_out,
    output logic             synced_comparator3_out
);
    initial {external_shutdown_input, synced_comparator1_out, synced_comparator2_out, synced_comparator3_out} = 4'h0;
    // The pin is asynchronous, so it moves off the edge to exercise the synchroniser.
    always @(posedge mclk) begin
        external_shutdown_input <= #1 cmd.pin;
        synced_comparator1_out <= cmd.cmp1;
        synced_comparator2_out <= cmd.cmp2;
        synced_comparator3_out <= cmd.cmp3;
    end
endmodule : shutdown_sources

/* File: bench/pwm_shutdown_src_timebase_tb.sv */
// Testbench for the shutdown source and time base block.
`timescale 1ns/1ps
module pwm_shutdown_src_timebase_tb
    import shutdown_timebase_pkg::*;
;
    logic              mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00, reg_rdata;
    logic [5:0]        pwm_in = 6'h15, pwm_out;
    logic              auto_shutdown, irq, external_shutdown_input;
    logic              synced_comparator1_out, synced_comparator2_out, synced_comparator3_out;
    shutdown_inputs_t  cmd = 4'h0;
    int                num_errors = 0, check_count = 0, cycles = 0;
    shutdown_timebase dut_u (.*);
    shutdown_sources  src_u (.*);
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rdchk
    task automatic t_reset;
        rdchk(OFF_SRC_SEL, 8'h00);
        rdchk(OFF_TB_LOW, 8'h00);
        rdchk(OFF_TB_HIGH, 8'h01);
        rdchk(4'hf, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_regs;
        wr(OFF_SRC_SEL, 8'hff);
        rdchk(OFF_SRC_SEL, 8'h8e);
        wr(OFF_TB_LOW, 8'h5a);
        wr(OFF_TB_HIGH, 8'ha5);
        rdchk(OFF_TB_LOW, 8'h5a);
        rdchk(OFF_TB_HIGH, 8'ha5);
        $display("register test done");
    endtask : t_regs
    task automatic t_src;
        logic [7:0] en [4] = '{8'h80, 8'h02, 8'h04, 8'h08};
        wr(OFF_LEVEL, 8'h2a);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_SRC_SEL, en[i]);
            cmd <= shutdown_inputs_t'(~(4'h1 << i));
            repeat (5) @(posedge mclk);
            #1 chk({7'h0, auto_shutdown}, 8'h00);
            chk({2'h0, pwm_out}, 8'h15);
            @(posedge mclk) cmd <= shutdown_inputs_t'(4'h1 << i);
            // The pin needs its two synchroniser stages on top of the model's edge.
            repeat (4) @(posedge mclk);
            #1 chk({7'h0, auto_shutdown}, 8'h01);
            chk({2'h0, pwm_out}, 8'h2a);
            @(posedge mclk) cmd <= 4'h0;
        end
        $display("source test done");
    endtask : t_src
    task automatic t_irq;
        wr(OFF_IRQ_CLEAR, 8'h03);
        wr(OFF_SRC_SEL, 8'h02);
        wr(OFF_IRQ_ENABLE, 8'h01);
        #1 chk({7'h0, irq}, 8'h00);
        @(posedge mclk) cmd <= 4'h2;
        repeat (3) @(posedge mclk);
        #1 chk({7'h0, irq}, 8'h01);
        rdchk(OFF_IRQ_STATUS, 8'h01);
        wr(OFF_IRQ_ENABLE, 8'h00);
        #1 chk({7'h0, irq}, 8'h00);
        wr(OFF_IRQ_ENABLE, 8'h01);
        #1 chk({7'h0, irq}, 8'h01);
        @(posedge mclk) cmd <= 4'h0;
        repeat (3) @(posedge mclk);
        wr(OFF_IRQ_CLEAR, 8'h03);
        #1 chk({7'h0, irq}, 8'h00);
        rdchk(OFF_IRQ_STATUS, 8'h00);
        $display("interrupt test done");
    endtask : t_irq
    task automatic t_run;
        wr(OFF_IRQ_CLEAR, 8'h03);
        wr(OFF_TB_HIGH, 8'hff);
        wr(OFF_TB_LOW, 8'hfd);
        wr(OFF_TB_CTRL, 8'h01);
        repeat (4) @(posedge mclk);
        wr(OFF_TB_CTRL, 8'h00);
        rdchk(OFF_TB_LOW, 8'h03);
        rdchk(OFF_TB_HIGH, 8'h00);
        rdchk(OFF_IRQ_STATUS, 8'h02);
        $display("counter test done");
    endtask : t_run
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_regs();
        t_src();
        t_irq();
        t_run();
        tally_and_finish();
    end
endmodule : pwm_shutdown_src_timebase_tb
bind shutdown_timebase shutdown_timebase_chk #(.N_OUT(N_OUT)) chk_u (.*);
